// file: ufr_params.svh
`ifndef UFR_PARAMS_SVH
`define UFR_PARAMS_SVH
`define UFR_ADDR_W         16
`define UFR_OFS_DMA_REQ    16'h409c
`define UFR_OFS_DMA_END    16'h40a0
`define UFR_OFS_FIC0       16'h40c0
`define UFR_OFS_FIC1       16'h40c4
`define UFR_OFS_DEND       16'h40d4
`define UFR_OFS_SRST       16'h40dc
`define UFR_OFS_MODC       16'h40e8
`define UFR_RST_BYTE       8'h00
`define UFR_BIT_EP2_RD     3
`define UFR_BIT_EP1_WR     2
`define UFR_BIT_DEDE2      4
`define UFR_BIT_DSPE2      3
`define UFR_BIT_DEDE1      2
`define UFR_BIT_BI_BOTH    5
`define UFR_BIT_BI_CPU     4
`define UFR_BIT_INT_CLR    2
`define UFR_BIT_CW_CLR     1
`define UFR_BIT_CR_CLR     0
`define UFR_BIT_BO_BOTH    1
`define UFR_BIT_BO_CPU     0
`define UFR_BIT_TOGGLE     6
`define UFR_BIT_INT_END    3
`define UFR_BIT_BI_END     1
`define UFR_BIT_CTL_END    0
`define UFR_BIT_SRST       0
`define UFR_BIT_FCD        6
`define UFR_FIFO_W         8
`define UFR_FIFO_D         8
`endif

// file: ufr_pkg.sv
package ufr_pkg;
	typedef logic [7:0] ufr_byte_t;
	typedef logic [15:0] ufr_addr_t;
endpackage

// file: ufr_fifo.sv
`timescale 1ns/1ns
module ufr_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         flush,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data,
	output logic [$clog2(D):0] count
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;
	assign in_ready  = (cnt_q != (AW+1)'(D)) & ~flush;
	assign out_valid = (cnt_q != '0) & ~flush;
	assign out_data  = mem_q[rp_q];
	assign count     = cnt_q;
	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
	endfunction
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= inc(wp_q);
			if (pop) rp_q <= inc(rp_q);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clock) begin
		if (push) mem_q[wp_q] <= in_data;
	end
endmodule

// file: ufr_regs.sv
`timescale 1ns/1ns
`include "ufr_params.svh"
// Notes on behaviour
// - Bit 3 mirrors endpoint 2 DMA read request
// - Reading end status clears it, not interrupts
// - Unsupported endpoint clears end status
// - Clear registers read 00h, self-clear pulses
// - Bulk-in both clear also drops NAK flag
// - Bit 4 empties CPU-side bulk-in FIFO
// - Interrupt clear ignored during NAK IN
// - Bulk-out bit 1 empties both FIFOs
// - Bulk-out CPU clear resets hardware NAK
// - Data-end reads only bit 6
// - Data-end bits pulse transmission, self-clear
// - Auto toggle when DMA fills CPU FIFO
// - Interrupt data-end sets NAK, transmits
// - Zero count sends null packet, else short
// - Control data-end sets write NAK, transmits
// - Empty sends null; data, not full short
// - Soft reset bit pulses, reads 00h
// - Mode bit cleared by resets or a firmware write of 0
// - Firmware write overrides hardware set
module ufr_regs
	import ufr_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               resetn,
	input  wire ufr_pkg::ufr_addr_t addr,
	input  wire logic               wr_en,
	input  wire logic               rd_en,
	input  wire ufr_pkg::ufr_byte_t wdata,
	output ufr_pkg::ufr_byte_t      rdata,
	input  wire logic               ep2_dma_read_req,
	input  wire logic               ep1_dma_write_req,
	input  wire logic               dma_end_ep1,
	input  wire logic               dma_end_ep2,
	input  wire logic               short_pkt_ep2,
	input  wire logic               ep_unsupported,
	input  wire logic               intin_token_active,
	input  wire logic               hw_set_bulkin_nak,
	input  wire logic               hw_set_intin_nak,
	input  wire logic               hw_set_bulkout_nak,
	input  wire logic               hw_set_ctrl_nak,
	input  wire logic               hw_set_force_cfg,
	input  wire logic               dma_in_valid,
	input  wire ufr_pkg::ufr_byte_t dma_in_data,
	output logic                    dma_in_ready,
	input  wire logic               sie_out_ready,
	output logic                    sie_out_valid,
	output ufr_pkg::ufr_byte_t      sie_out_data,
	output logic                    bulkin_nak_flag,
	output logic                    intin_nak_flag,
	output logic                    bulkout_nak_flag,
	output logic                    ctrl_write_nak_flag,
	output logic                    bulkin_cpu_fifo_clear,
	output logic                    bulkin_both_fifo_clear,
	output logic                    intin_fifo_clear,
	output logic                    ctrl_write_fifo_clear,
	output logic                    ctrl_read_fifo_clear,
	output logic                    bulkout_both_fifo_clear,
	output logic                    bulkout_cpu_fifo_clear,
	output logic                    bulkin_toggle,
	output logic                    intin_send,
	output logic                    bulkin_send,
	output logic                    ctrl_send,
	input  wire logic [6:0]         intin_count,
	input  wire logic [6:0]         ctrl_count,
	input  wire logic               ctrl_fifo_full,
	output logic                    intin_zero_len,
	output logic                    ctrl_zero_len,
	output logic                    usb_function_reset,
	output logic                    force_config_desc_to_cpu
);
	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rs1_q;
	logic rs2_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end
	wire rst_n = rs2_q;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic hit(input ufr_addr_t a, input ufr_addr_t ofs);
		hit = (a == ofs);
	endfunction
	wire wr_fic0 = wr_en & hit(addr, `UFR_OFS_FIC0);
	wire wr_fic1 = wr_en & hit(addr, `UFR_OFS_FIC1);
	wire wr_dend = wr_en & hit(addr, `UFR_OFS_DEND);
	wire wr_srst = wr_en & hit(addr, `UFR_OFS_SRST);
	wire wr_modc = wr_en & hit(addr, `UFR_OFS_MODC);
	wire rd_dms1 = rd_en & hit(addr, `UFR_OFS_DMA_END);
	// Writing 0 does nothing: only set bits act
	wire bi_both = wr_fic0 & wdata[`UFR_BIT_BI_BOTH];
	wire bi_cpu  = wr_fic0 & wdata[`UFR_BIT_BI_CPU];
	// Guard keeps a pending IN token consistent
	wire int_clr = wr_fic0 & wdata[`UFR_BIT_INT_CLR]
		& ~(intin_token_active & intin_nak_flag);
	wire cw_clr  = wr_fic0 & wdata[`UFR_BIT_CW_CLR];
	wire cr_clr  = wr_fic0 & wdata[`UFR_BIT_CR_CLR];
	wire bo_both = wr_fic1 & wdata[`UFR_BIT_BO_BOTH];
	wire bo_cpu  = wr_fic1 & wdata[`UFR_BIT_BO_CPU];
	wire int_end = wr_dend & wdata[`UFR_BIT_INT_END];
	wire bi_end  = wr_dend & wdata[`UFR_BIT_BI_END];
	wire ctl_end = wr_dend & wdata[`UFR_BIT_CTL_END];
	wire srst    = wr_srst & wdata[`UFR_BIT_SRST];

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic       toggle_en_q;
	logic       fcd_q;
	logic       fw_fcd_q;
	logic [2:0] dms1_q;
	logic       bi_nak_q, it_nak_q, bo_nak_q, bo_nak_hw_q, cw_nak_q;
	logic       req2_q, req1_q;
	logic [2:0] dms1_d;
	assign dms1_d = {dma_end_ep2, short_pkt_ep2, dma_end_ep1};
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req2_q <= 1'b0;
			req1_q <= 1'b0;
		end else begin
			req2_q <= ep2_dma_read_req;
			req1_q <= ep1_dma_write_req;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dms1_q <= 3'h0;
		end else if (ep_unsupported | srst) begin
			dms1_q <= 3'h0;
		end else if (rd_dms1) begin
			dms1_q <= dms1_d;
		end else begin
			dms1_q <= dms1_q | dms1_d;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			toggle_en_q <= 1'b0;
		end else if (srst) begin
			toggle_en_q <= 1'b0;
		end else if (wr_dend) begin
			toggle_en_q <= wdata[`UFR_BIT_TOGGLE];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fcd_q    <= 1'b0;
			fw_fcd_q <= 1'b0;
		end else if (srst) begin
			fcd_q    <= 1'b0;
			fw_fcd_q <= 1'b0;
		end else if (wr_modc) begin
			fcd_q    <= wdata[`UFR_BIT_FCD];
			fw_fcd_q <= 1'b1;
		end else if (hw_set_force_cfg & ~fw_fcd_q) begin
			fcd_q <= 1'b1;
		end
	end
	// NAK flags: a hardware set wins over a firmware FIFO clear in the same cycle, but soft reset wins over it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bi_nak_q    <= 1'b0;
			it_nak_q    <= 1'b0;
			bo_nak_q    <= 1'b0;
			bo_nak_hw_q <= 1'b0;
			cw_nak_q    <= 1'b0;
		end else if (srst) begin
			bi_nak_q    <= 1'b0;
			it_nak_q    <= 1'b0;
			bo_nak_q    <= 1'b0;
			bo_nak_hw_q <= 1'b0;
			cw_nak_q    <= 1'b0;
		end else begin
			bi_nak_q <= hw_set_bulkin_nak | bi_end | (bi_nak_q & ~bi_both);
			it_nak_q <= hw_set_intin_nak | int_end | (it_nak_q & ~int_clr);
			if (hw_set_bulkout_nak) begin
				bo_nak_q    <= 1'b1;
				bo_nak_hw_q <= 1'b1;
			end else if (bo_cpu & bo_nak_hw_q) begin
				bo_nak_q    <= 1'b0;
				bo_nak_hw_q <= 1'b0;
			end
			cw_nak_q <= hw_set_ctrl_nak | ctl_end | cw_nak_q;
		end
	end

	// ----------------------------------------
	// Bulk-in data buffer
	// ----------------------------------------
	logic [$clog2(`UFR_FIFO_D):0] bi_cnt;
	wire                          fifo_flush = bi_both | bi_cpu | srst;
	ufr_fifo #(
		.W(`UFR_FIFO_W),
		.D(`UFR_FIFO_D)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.flush     (fifo_flush),
		.in_valid  (dma_in_valid),
		.in_ready  (dma_in_ready),
		.in_data   (dma_in_data),
		.out_valid (sie_out_valid),
		.out_ready (sie_out_ready),
		.out_data  (sie_out_data),
		.count     (bi_cnt)
	);
	// Toggle once on the push that fills the buffer
	wire fill_now = dma_in_valid & dma_in_ready
		& (bi_cnt == ($clog2(`UFR_FIFO_D)+1)'(`UFR_FIFO_D - 1));

	// ----------------------------------------
	// Pulses and read mux
	// ----------------------------------------
	logic [7:0] rd_d;
	assign rd_d =
		hit(addr, `UFR_OFS_DMA_REQ) ? {4'h0, req2_q, req1_q, 2'h0} :
		hit(addr, `UFR_OFS_DMA_END) ? {3'h0, dms1_q, 2'h0} :
		hit(addr, `UFR_OFS_DEND)    ? {1'b0, toggle_en_q, 6'h00} :
		hit(addr, `UFR_OFS_MODC)    ? {1'b0, fcd_q, 6'h00} :
		`UFR_RST_BYTE;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `UFR_RST_BYTE;
		end else begin
			rdata <= rd_en ? rd_d : `UFR_RST_BYTE;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bulkin_both_fifo_clear <= 1'b0;
			bulkin_cpu_fifo_clear  <= 1'b0;
			intin_fifo_clear       <= 1'b0;
			ctrl_write_fifo_clear  <= 1'b0;
			ctrl_read_fifo_clear   <= 1'b0;
		end else begin
			bulkin_both_fifo_clear <= bi_both;
			bulkin_cpu_fifo_clear  <= bi_cpu;
			intin_fifo_clear       <= int_clr;
			ctrl_write_fifo_clear  <= cw_clr;
			ctrl_read_fifo_clear   <= cr_clr;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bulkout_both_fifo_clear <= 1'b0;
			bulkout_cpu_fifo_clear  <= 1'b0;
		end else begin
			bulkout_both_fifo_clear <= bo_both;
			bulkout_cpu_fifo_clear  <= bo_cpu;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bulkin_toggle <= 1'b0;
			intin_send    <= 1'b0;
			bulkin_send   <= 1'b0;
			ctrl_send     <= 1'b0;
		end else begin
			bulkin_toggle <= (toggle_en_q & fill_now) | bi_end;
			intin_send    <= int_end;
			bulkin_send   <= bi_end;
			ctrl_send     <= ctl_end & ((ctrl_count == 7'h00) | ~ctrl_fifo_full);
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			intin_zero_len     <= 1'b0;
			ctrl_zero_len      <= 1'b0;
			usb_function_reset <= 1'b0;
		end else begin
			intin_zero_len     <= int_end & (intin_count == 7'h00);
			ctrl_zero_len      <= ctl_end & (ctrl_count == 7'h00);
			usb_function_reset <= srst;
		end
	end
	assign bulkin_nak_flag          = bi_nak_q;
	assign intin_nak_flag           = it_nak_q;
	assign bulkout_nak_flag         = bo_nak_q;
	assign ctrl_write_nak_flag      = cw_nak_q;
	assign force_config_desc_to_cpu = fcd_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_req_tracks: assert property (@(posedge clock) disable iff (!rst_n)
		req2_q == $past(ep2_dma_read_req)) else $error("req bit lag");
	chk_end_rdclr: assert property (@(posedge clock) disable iff (!rst_n)
		rd_dms1 && !ep_unsupported && !srst |=> dms1_q == $past(dms1_d))
		else $error("end status not cleared by read");
	chk_unsup_clear: assert property (@(posedge clock) disable iff (!rst_n)
		ep_unsupported |=> dms1_q == 3'h0) else $error("unsupported not cleared");
	chk_wo_read: assert property (@(posedge clock) disable iff (!rst_n)
		rd_en && hit(addr, `UFR_OFS_FIC0) |=> rdata == 8'h00) else $error("fic0 reads nonzero");
	chk_bi_nak_clr: assert property (@(posedge clock) disable iff (!rst_n)
		bi_both && !hw_set_bulkin_nak && !bi_end |=> !bulkin_nak_flag)
		else $error("bulk-in nak kept");
	chk_int_guard: assert property (@(posedge clock) disable iff (!rst_n)
		wr_fic0 && intin_token_active && intin_nak_flag |=> !intin_fifo_clear)
		else $error("int clear not ignored");
	chk_end_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		int_end |=> intin_send ##1 !intin_send || $past(int_end))
		else $error("send not pulsed");
	chk_zero_len: assert property (@(posedge clock) disable iff (!rst_n)
		int_end && intin_count == 7'h00 |=> intin_zero_len && intin_nak_flag)
		else $error("zero length missed");
	chk_mode_rst: assert property (@(posedge clock) disable iff (!rst_n)
		srst |=> !force_config_desc_to_cpu) else $error("mode bit not cleared");
	chk_req1_tracks: assert property (@(posedge clock) disable iff (!rst_n)
		req1_q == $past(ep1_dma_write_req))
		else $error("ep1 req bit lag");
	chk_rd_idle: assert property (@(posedge clock) disable iff (!rst_n)
		!rd_en |=> rdata == `UFR_RST_BYTE)
		else $error("read data not idle");
	chk_bi_cpu_flush: assert property (@(posedge clock) disable iff (!rst_n)
		bi_cpu |=> bulkin_cpu_fifo_clear && bi_cnt == '0)
		else $error("cpu fifo not emptied");
	chk_int_clr_ok: assert property (@(posedge clock) disable iff (!rst_n)
		int_clr && !hw_set_intin_nak |=> intin_fifo_clear && !intin_nak_flag)
		else $error("int clear not taken");
	chk_bo_both: assert property (@(posedge clock) disable iff (!rst_n)
		bo_both |=> bulkout_both_fifo_clear)
		else $error("bulk-out clear missed");
	chk_bo_nak_clr: assert property (@(posedge clock) disable iff (!rst_n)
		bo_cpu && bo_nak_hw_q && !hw_set_bulkout_nak |=> !bulkout_nak_flag)
		else $error("bulk-out nak kept");
	chk_dend_read: assert property (@(posedge clock) disable iff (!rst_n)
		rd_en && hit(addr, `UFR_OFS_DEND) |=> rdata[7] == 1'b0 && rdata[5:0] == 6'h00)
		else $error("data end reads stray bits");
	chk_auto_toggle: assert property (@(posedge clock) disable iff (!rst_n)
		toggle_en_q && fill_now |=> bulkin_toggle)
		else $error("auto toggle missed");
	chk_no_toggle: assert property (@(posedge clock) disable iff (!rst_n)
		!toggle_en_q && !bi_end |=> !bulkin_toggle)
		else $error("toggle without cause");
	chk_int_nak_set: assert property (@(posedge clock) disable iff (!rst_n)
		int_end |=> intin_nak_flag && intin_send)
		else $error("int data end not acted on");
	chk_int_short: assert property (@(posedge clock) disable iff (!rst_n)
		int_end && intin_count != 7'h00 |=> intin_send && !intin_zero_len)
		else $error("int short packet missed");
	chk_ctl_nak: assert property (@(posedge clock) disable iff (!rst_n)
		ctl_end |=> ctrl_write_nak_flag)
		else $error("ctrl write nak not set");
	chk_ctl_null: assert property (@(posedge clock) disable iff (!rst_n)
		ctl_end && ctrl_count == 7'h00 |=> ctrl_send && ctrl_zero_len)
		else $error("ctrl null packet missed");
	chk_ctl_full: assert property (@(posedge clock) disable iff (!rst_n)
		ctl_end && ctrl_count != 7'h00 && ctrl_fifo_full |=> !ctrl_send)
		else $error("short packet on full fifo");
	chk_srst_self: assert property (@(posedge clock) disable iff (!rst_n)
		!srst |=> !usb_function_reset)
		else $error("soft reset not self cleared");
	chk_fw_wins: assert property (@(posedge clock) disable iff (!rst_n)
		wr_modc |=> force_config_desc_to_cpu == $past(wdata[`UFR_BIT_FCD]))
		else $error("firmware mode write lost");
	chk_mode_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!wr_modc && !srst && !hw_set_force_cfg |=> $stable(force_config_desc_to_cpu))
		else $error("mode bit changed unprompted");
endmodule

// file: ufr_far_side.sv
`timescale 1ns/1ns
module ufr_far_side (
	input  wire logic               clock,
	input  wire logic               fill_en,
	input  wire logic               drain_en,
	input  wire logic               dma_in_ready,
	input  wire logic               sie_out_valid,
	input  wire ufr_pkg::ufr_byte_t sie_out_data,
	output logic                    dma_in_valid,
	output ufr_pkg::ufr_byte_t      dma_in_data,
	output logic                    sie_out_ready,
	output int                      n_sent,
	output int                      n_got,
	output int                      n_bad
);
	import ufr_pkg::*;
	initial begin
		dma_in_valid = 1'h0;
		dma_in_data = 8'h00;
		sie_out_ready = 1'h0;
		n_sent = 0;
		n_got = 0;
		n_bad = 0;
	end
	// Word held until taken while fill_en is high; idle data inverts so stale bytes never match
	always @(posedge clock) begin
		if (dma_in_valid && dma_in_ready)
			n_sent++;
		if (sie_out_valid && sie_out_ready) begin
			if (sie_out_data !== n_got[7:0])
				n_bad++;
			n_got++;
		end
		dma_in_valid <= fill_en;
		dma_in_data <= fill_en ? n_sent[7:0] : ~dma_in_data;
		sie_out_ready <= drain_en;
	end
endmodule

// file: usb_fn_fifo_dma_ctrl_regs_tb.sv
`timescale 1ns/1ns
`include "ufr_params.svh"
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", what, exp, got); end end
module usb_fn_fifo_dma_ctrl_regs_tb;
	import ufr_pkg::*;
	// ----------------
	// Signals
	// ----------------
	logic clock, resetn, wr_en, rd_en, fill_en, drain_en, ctrl_fifo_full, hw_set_ctrl_nak;
	ufr_addr_t addr;
	ufr_byte_t wdata, rdata, dma_in_data, sie_out_data;
	logic ep2_dma_read_req, ep1_dma_write_req, dma_end_ep1, dma_end_ep2, short_pkt_ep2;
	logic ep_unsupported, intin_token_active, hw_set_bulkin_nak, hw_set_intin_nak;
	logic hw_set_bulkout_nak, hw_set_force_cfg, dma_in_valid, dma_in_ready;
	logic sie_out_ready, sie_out_valid, bulkin_nak_flag, intin_nak_flag;
	logic bulkout_nak_flag, ctrl_write_nak_flag, bulkin_cpu_fifo_clear, bulkin_both_fifo_clear;
	logic intin_fifo_clear, ctrl_write_fifo_clear, ctrl_read_fifo_clear, bulkout_both_fifo_clear;
	logic bulkout_cpu_fifo_clear, bulkin_toggle, intin_send, bulkin_send, ctrl_send;
	logic intin_zero_len, ctrl_zero_len, usb_function_reset, force_config_desc_to_cpu;
	logic [6:0] intin_count, ctrl_count;
	int n_sent, n_got, n_bad, n_tog, miscompares, n_compared;
	wire [7:0] clr0 = {2'h0, bulkin_both_fifo_clear, bulkin_cpu_fifo_clear, 1'h0,
		intin_fifo_clear, ctrl_write_fifo_clear, ctrl_read_fifo_clear};
	wire [7:0] clr1 = {6'h00, bulkout_both_fifo_clear, bulkout_cpu_fifo_clear};
	wire [7:0] dend = {4'h0, intin_send, 1'h0, bulkin_send, ctrl_send};
	ufr_regs ufr_regs_i (.clock, .resetn, .addr, .wr_en, .rd_en, .wdata, .rdata,
		.ep2_dma_read_req, .ep1_dma_write_req, .dma_end_ep1, .dma_end_ep2, .short_pkt_ep2,
		.ep_unsupported, .intin_token_active, .hw_set_bulkin_nak, .hw_set_intin_nak,
		.hw_set_bulkout_nak, .hw_set_ctrl_nak, .hw_set_force_cfg, .dma_in_valid, .dma_in_data,
		.dma_in_ready, .sie_out_ready, .sie_out_valid, .sie_out_data, .bulkin_nak_flag,
		.intin_nak_flag, .bulkout_nak_flag, .ctrl_write_nak_flag, .bulkin_cpu_fifo_clear,
		.bulkin_both_fifo_clear, .intin_fifo_clear, .ctrl_write_fifo_clear,
		.ctrl_read_fifo_clear, .bulkout_both_fifo_clear, .bulkout_cpu_fifo_clear,
		.bulkin_toggle, .intin_send, .bulkin_send, .ctrl_send, .intin_count, .ctrl_count,
		.ctrl_fifo_full, .intin_zero_len, .ctrl_zero_len, .usb_function_reset,
		.force_config_desc_to_cpu);
	ufr_far_side ufr_far_side_i (.clock, .fill_en, .drain_en, .dma_in_ready, .sie_out_valid,
		.sie_out_data, .dma_in_valid, .dma_in_data, .sie_out_ready, .n_sent, .n_got, .n_bad);
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) if (bulkin_toggle === 1'h1) n_tog++;
	// ----------------
	// Bus tasks, all entered and left at a falling edge
	// ----------------
	task automatic wr(input ufr_addr_t a, input ufr_byte_t d);
		// Idle edge first, so a strobe never drops and rises in one step
		@(negedge clock);
		addr = a;
		wdata = d;
		wr_en = 1'h1;
		@(negedge clock);
		wr_en = 1'h0;
	endtask
	task automatic rd_chk(input string what, input ufr_addr_t a, input ufr_byte_t e);
		@(negedge clock);
		addr = a;
		rd_en = 1'h1;
		@(negedge clock);
		rd_en = 1'h0;
		`CHK(what, e, rdata)
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge clock);
		s = 1'h0;
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset_values();
		rd_chk("request status", `UFR_OFS_DMA_REQ, 8'h00);
		rd_chk("end status", `UFR_OFS_DMA_END, 8'h00);
		rd_chk("clear 0", `UFR_OFS_FIC0, 8'h00);
		rd_chk("clear 1", `UFR_OFS_FIC1, 8'h00);
		rd_chk("data end", `UFR_OFS_DEND, 8'h00);
		rd_chk("soft reset", `UFR_OFS_SRST, 8'h00);
		rd_chk("mode", `UFR_OFS_MODC, 8'h00);
		rd_chk("unmapped", 16'h40d8, 8'h00);
		$display("reset values done");
	endtask
	task automatic t_dma_status();
		ep2_dma_read_req = 1'h1;
		@(negedge clock);
		rd_chk("ep2 request", `UFR_OFS_DMA_REQ, 8'h08);
		ep2_dma_read_req = 1'h0;
		ep1_dma_write_req = 1'h1;
		@(negedge clock);
		rd_chk("ep1 request", `UFR_OFS_DMA_REQ, 8'h04);
		ep1_dma_write_req = 1'h0;
		@(negedge clock);
		rd_chk("request gone", `UFR_OFS_DMA_REQ, 8'h00);
		{dma_end_ep1, dma_end_ep2, short_pkt_ep2} = 3'h7;
		@(negedge clock);
		{dma_end_ep1, dma_end_ep2, short_pkt_ep2} = 3'h0;
		@(negedge clock);
		rd_chk("end status set", `UFR_OFS_DMA_END, 8'h1c);
		rd_chk("end status read clear", `UFR_OFS_DMA_END, 8'h00);
		pulse(dma_end_ep2);
		pulse(ep_unsupported);
		rd_chk("end status unsupported", `UFR_OFS_DMA_END, 8'h00);
		$display("dma status done");
	endtask
	task automatic t_fifo_clears();
		int b;
		pulse(hw_set_bulkin_nak);
		for (b = 0; b < 6; b++) begin
			wr(`UFR_OFS_FIC0, 8'h01 << b);
			`CHK("clear 0 pulse", (b == 3) ? 8'h00 : 8'h01 << b, clr0)
			@(negedge clock);
			`CHK("clear 0 self clear", 8'h00, clr0)
		end
		`CHK("bulk-in nak", 1'h0, bulkin_nak_flag)
		pulse(hw_set_bulkout_nak);
		wr(`UFR_OFS_FIC1, 8'h01);
		`CHK("bulk-out cpu clear", 8'h01, clr1)
		@(negedge clock);
		`CHK("bulk-out nak", 1'h0, bulkout_nak_flag)
		wr(`UFR_OFS_FIC1, 8'h02);
		`CHK("bulk-out both clear", 8'h02, clr1)
		wr(`UFR_OFS_FIC1, 8'h00);
		`CHK("zero write", 8'h00, clr1)
		pulse(hw_set_intin_nak);
		intin_token_active = 1'h1;
		wr(`UFR_OFS_FIC0, 8'h04);
		`CHK("int clear refused", 1'h0, intin_fifo_clear)
		@(negedge clock);
		`CHK("int nak kept", 1'h1, intin_nak_flag)
		intin_token_active = 1'h0;
		wr(`UFR_OFS_FIC0, 8'h04);
		`CHK("int clear taken", 1'h1, intin_fifo_clear)
		@(negedge clock);
		`CHK("int nak cleared", 1'h0, intin_nak_flag)
		$display("fifo clears done");
	endtask
	task automatic t_data_end();
		int b;
		logic [3:0] v;
		for (b = 0; b < 4; b++) begin
			wr(`UFR_OFS_DEND, 8'h01 << b);
			`CHK("data end pulse", (b == 2) ? 8'h00 : 8'h01 << b, dend)
			`CHK("int null packet", b == 3, intin_zero_len)
			`CHK("ctrl null packet", b == 0, ctrl_zero_len)
			@(negedge clock);
			`CHK("data end self clear", 8'h00, dend)
		end
		`CHK("int nak set", 1'h1, intin_nak_flag)
		`CHK("ctrl nak set", 1'h1, ctrl_write_nak_flag)
		intin_count = 7'h05;
		ctrl_count = 7'h05;
		wr(`UFR_OFS_DEND, 8'h09);
		v = {intin_send, ctrl_send, intin_zero_len, ctrl_zero_len};
		`CHK("short packets", 4'hc, v)
		ctrl_fifo_full = 1'h1;
		wr(`UFR_OFS_DEND, 8'h01);
		`CHK("ctrl full no short", 1'h0, ctrl_send)
		ctrl_fifo_full = 1'h0;
		wr(`UFR_OFS_DEND, 8'h00);
		`CHK("zero write", 8'h00, dend)
		wr(`UFR_OFS_DEND, 8'hcb);
		rd_chk("data end read", `UFR_OFS_DEND, 8'h40);
		$display("data end done");
	endtask
	task automatic t_fifo(input logic auto);
		int i;
		int base;
		wr(`UFR_OFS_DEND, auto ? 8'h40 : 8'h00);
		n_tog = 0;
		base = n_sent;
		fill_en = 1'h1;
		for (i = 0; i < 40 && dma_in_ready !== 1'h0; i++) @(negedge clock);
		fill_en = 1'h0;
		repeat (2) @(negedge clock);
		`CHK("words taken", `UFR_FIFO_D, n_sent - base)
		`CHK("auto toggle", auto, n_tog != 0)
		drain_en = 1'h1;
		for (i = 0; i < 40 && sie_out_valid !== 1'h0; i++) @(negedge clock);
		drain_en = 1'h0;
		`CHK("words drained", n_sent, n_got)
		`CHK("drain order", 0, n_bad)
		$display("fifo fill and drain done");
	endtask
	task automatic t_mode();
		pulse(hw_set_force_cfg);
		@(negedge clock);
		rd_chk("mode hw set", `UFR_OFS_MODC, 8'h40);
		wr(`UFR_OFS_MODC, 8'h00);
		@(negedge clock);
		`CHK("firmware override", 1'h0, force_config_desc_to_cpu)
		wr(`UFR_OFS_MODC, 8'h40);
		wr(`UFR_OFS_SRST, 8'h01);
		`CHK("soft reset pulse", 1'h1, usb_function_reset)
		@(negedge clock);
		`CHK("soft reset self clear", 1'h0, usb_function_reset)
		rd_chk("mode after soft reset", `UFR_OFS_MODC, 8'h00);
		rd_chk("soft reset read", `UFR_OFS_SRST, 8'h00);
		$display("mode and soft reset done");
	endtask
	task automatic report_and_stop();
		$display("compared %0d, wrong %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------
	// Main sequence and watchdog
	// ----------------
	initial begin
		{wr_en, rd_en, fill_en, drain_en, ctrl_fifo_full, hw_set_ctrl_nak, ep2_dma_read_req} = '0;
		{ep1_dma_write_req, dma_end_ep1, dma_end_ep2, short_pkt_ep2, ep_unsupported} = '0;
		{intin_token_active, hw_set_bulkin_nak, hw_set_intin_nak, hw_set_bulkout_nak} = '0;
		hw_set_force_cfg = 1'h0;
		addr = 16'h0000;
		wdata = 8'h00;
		intin_count = 7'h00;
		ctrl_count = 7'h00;
		{n_tog, miscompares, n_compared} = '0;
		resetn = 1'h0;
		repeat (10) @(negedge clock);
		resetn = 1'h1;
		repeat (4) @(negedge clock);
		t_reset_values();
		t_dma_status();
		t_fifo_clears();
		t_data_end();
		t_fifo(1'h1);
		t_fifo(1'h0);
		t_mode();
		report_and_stop();
	end
	// Whole run is under 200 cycles; the 3000-cycle limit leaves ample slack
	initial begin
		#(3000 * 100);
		miscompares++;
		report_and_stop();
	end
endmodule
